/* include/rems_pkg.sv */
package rems_pkg;

	// ==========================================
	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int WDT_HOLD_NS = 50;
	localparam int WDT_HOLD_CYC = (WDT_HOLD_NS * CLK_MHZ + 999) / 1000;

	// ==========================================
	// Operating modes on the mode select pins
	localparam logic [2:0] MODE1 = 3'h1;
	localparam logic [2:0] MODE2 = 3'h2;
	localparam logic [2:0] MODE3 = 3'h3;
	localparam logic [2:0] MODE4 = 3'h4;
	localparam logic [2:0] MODE_RST = 3'h0;

	// ==========================================
	// Address lines, areas and bus widths
	localparam int AREAS = 8;
	localparam logic [23:0] ADDR_OE_1M = 24'h0FFFFF;
	localparam logic [23:0] ADDR_OE_16M = 24'hFFFFFF;
	localparam logic [7:0] ABW_ALL8 = 8'h00;
	localparam logic [7:0] ABW_ALL16 = 8'hFF;

	// ==========================================
	// Exception vector numbers
	localparam logic [5:0] VEC_RESET = 6'h00;
	localparam logic [5:0] VEC_RSV_LAST = 6'h06;
	localparam logic [5:0] VEC_NMI = 6'h07;
	localparam logic [5:0] VEC_TRAP0 = 6'h08;
	localparam logic [5:0] VEC_IRQ0 = 6'h0C;
	localparam logic [5:0] VEC_INT_FIRST = 6'h14;
	localparam logic [5:0] VEC_INT_LAST = 6'h3C;

	// ==========================================
	// Condition code layout and stack frame
	localparam int CCR_I_BIT = 7;
	localparam logic [31:0] STACK_STEP = 32'h00000004;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_WDT,
		ST_PUSH,
		ST_VEC,
		ST_FIRST,
		ST_RUN
	} rems_state_t;

endpackage

/* hw/rems_sync.sv */
`timescale 1ns/1ps
module rems_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rems_sync_t;

	rems_sync_t r;
	rems_sync_t next_r;

	// ==========================================
	// A change counts only once two late stages agree.
	always_comb begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3) begin
			next_r.q = r.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= {INIT, INIT, INIT, INIT};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.q;

endmodule

/* hw/rems_mode.sv */
`timescale 1ns/1ps
module rems_mode (
	input wire logic clk,
	input wire logic rst,
	input wire logic latch,
	input wire logic [2:0] mode_select_pins,
	input wire logic [7:0] area_bus_width_register,
	output logic mode_valid,
	output logic [2:0] mode,
	output logic [23:0] addr_oe,
	output logic p5_addr_sel,
	output logic bus16,
	output logic p4_data_sel,
	output logic [7:0] abw_init,
	output logic [7:0] area16
);

	typedef struct packed {
		logic [2:0] mode;
		logic valid;
		logic [23:0] addr_oe;
		logic p5_addr;
		logic bus16;
		logic [7:0] abw_init;
		logic [7:0] area16;
	} rems_mode_t;

	rems_mode_t r;
	rems_mode_t next_r;

	// ==========================================
	// The pins are caught once per reset release; they must not move afterwards.
	always_comb begin
		next_r = r;
		if (latch) begin
			next_r.mode = mode_select_pins; // [RULE23]
			unique case (mode_select_pins)
				rems_pkg::MODE1, rems_pkg::MODE2: begin
					next_r.valid = 1'b1;
					next_r.addr_oe = rems_pkg::ADDR_OE_1M; // [RULE1]
					next_r.p5_addr = 1'b0; // [RULE6]
				end
				rems_pkg::MODE3, rems_pkg::MODE4: begin
					next_r.valid = 1'b1;
					next_r.addr_oe = rems_pkg::ADDR_OE_16M; // [RULE2]
					next_r.p5_addr = 1'b1; // [RULE6]
				end
				default: begin
					next_r.valid = 1'b0; // [RULE23]
					next_r.addr_oe = rems_pkg::ADDR_OE_1M;
					next_r.p5_addr = 1'b0;
				end
			endcase
			if (mode_select_pins == rems_pkg::MODE2 || mode_select_pins == rems_pkg::MODE4) begin
				next_r.abw_init = rems_pkg::ABW_ALL16; // [RULE4]
			end else begin
				next_r.abw_init = rems_pkg::ABW_ALL8; // [RULE3]
			end
		end
		// A set bit marks a 16-bit area, so one bit widens the bus and only all clear narrows it.
		next_r.area16 = area_bus_width_register; // [RULE7]
		next_r.bus16 = |area_bus_width_register; // [RULE3] [RULE4]
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{mode: rems_pkg::MODE_RST, valid: 1'b0, addr_oe: rems_pkg::ADDR_OE_1M,
				p5_addr: 1'b0, bus16: 1'b0, abw_init: rems_pkg::ABW_ALL8, area16: rems_pkg::ABW_ALL8};
		end else begin
			r <= next_r;
		end
	end

	assign mode_valid = r.valid;
	assign mode = r.mode;
	assign addr_oe = r.addr_oe;
	assign p5_addr_sel = r.p5_addr;
	assign bus16 = r.bus16;
	assign p4_data_sel = r.bus16; // [RULE5]
	assign abw_init = r.abw_init;
	assign area16 = r.area16;

endmodule

/* hw/rems_top.sv */
// Notes on behaviour
// [RULE1] Modes 1 and 2 drive twenty address lines.
// [RULE2] Modes 3 and 4 drive twenty-four address lines.
// [RULE3] Modes 1, 3 start 8-bit; any 16-bit area widens.
// [RULE4] Modes 2, 4 start 16-bit; all 8-bit narrows.
// [RULE5] Port 4 is data in 16-bit bus mode.
// [RULE6] Upper port 5 carries high address in modes 3, 4.
// [RULE7] Eight areas, each with its own width.
// [RULE8] Reset beats interrupts, interrupts beat trap.
// [RULE9] Traps are taken regardless of the mask.
// [RULE10] Interrupts wait for instruction or exception end.
// [RULE11] Trap or interrupt: push, mask, vector fetch.
// [RULE12] Reset skips the push, masks, then vectors.
// [RULE13] Each source has its own fixed vector number.
// [RULE14] Vector numbers one to six are never used.
// [RULE15] Low reset input halts and initialises everything.
// [RULE16] Reset handling starts on the rising edge.
// [RULE17] Watchdog overflow also resets the device.
// [RULE18] Reset source holds power-up reset 20 ms.
// [RULE19] Running reset pulse lasts ten clocks or more.
// [RULE20] Reset masks, reads vector at zero, jumps.
// [RULE21] All interrupts, NMI included, blocked after reset.
// [RULE22] First instruction runs before any interrupt.
// [RULE23] Mode codes 1 to 4 valid, pins fixed.
// [RULE24] Vector address is four times vector number.
// [RULE25] Interrupt block lasts until first instruction ends.
`timescale 1ns/1ps
module rems_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_input_n,
	input wire logic wdt_overflow,
	input wire logic [2:0] mode_select_pins,
	input wire logic [7:0] area_bus_width_register,
	input wire logic nmi_req,
	input wire logic [7:0] external_request_inputs,
	input wire logic int_req,
	input wire logic [5:0] int_vec,
	input wire logic trap_instruction,
	input wire logic [1:0] trap_num,
	input wire logic instr_done,
	input wire logic [23:0] program_counter,
	input wire logic [7:0] condition_code_register,
	input wire logic [31:0] stack_pointer,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic cpu_halt,
	output logic periph_reset,
	output logic cpu_hold,
	output logic set_i_mask,
	output logic load_pc,
	output logic [31:0] new_pc,
	output logic load_sp,
	output logic [31:0] new_sp,
	output logic exc_accept,
	output logic [5:0] exc_vector,
	output logic int_blocked,
	output logic mode_valid,
	output logic [2:0] mode,
	output logic [23:0] addr_oe,
	output logic p5_addr_sel,
	output logic p4_data_sel,
	output logic bus16,
	output logic [7:0] abw_init,
	output logic [7:0] area16
);

	typedef struct packed {
		rems_pkg::rems_state_t state;
		logic [3:0] cnt;
		logic [5:0] vec;
		logic trap_pend;
		logic [1:0] trap_sel;
		logic after_exc;
		logic blocked;
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic halt;
		logic set_i;
		logic load_pc;
		logic [31:0] pc;
		logic load_sp;
		logic [31:0] sp;
		logic accept;
		logic latch;
	} rems_top_t;

	rems_top_t r;
	rems_top_t next_r;
	logic rn_sync;
	logic int_pend;
	logic [5:0] int_sel;

	// ==========================================
	// Pin synchronisers and mode decode
	rems_sync #(.W(1), .INIT(1'b0)) u_rn_sync (
		.clk(clk),
		.rst(rst),
		.d(reset_input_n),
		.q(rn_sync)
	);

	logic [2:0] md_sync;

	rems_sync #(.W(3), .INIT(rems_pkg::MODE_RST)) u_md_sync (
		.clk(clk),
		.rst(rst),
		.d(mode_select_pins),
		.q(md_sync)
	);

	rems_mode u_mode (
		.clk(clk),
		.rst(rst),
		.latch(r.latch),
		.mode_select_pins(md_sync),
		.area_bus_width_register(area_bus_width_register),
		.mode_valid(mode_valid),
		.mode(mode),
		.addr_oe(addr_oe),
		.p5_addr_sel(p5_addr_sel),
		.bus16(bus16),
		.p4_data_sel(p4_data_sel),
		.abw_init(abw_init),
		.area16(area16)
	);

	// ==========================================
	// Interrupt source selection
	// Arbitration between maskable sources is fixed here; level priorities live elsewhere.
	always_comb begin
		int_pend = 1'b0;
		int_sel = rems_pkg::VEC_NMI;
		if (!condition_code_register[rems_pkg::CCR_I_BIT]) begin
			if (int_req && int_vec >= rems_pkg::VEC_INT_FIRST && int_vec <= rems_pkg::VEC_INT_LAST) begin
				int_pend = 1'b1;
				int_sel = int_vec; // [RULE13] [RULE14]
			end
			for (int i = 7; i >= 0; i--) begin
				if (external_request_inputs[i]) begin
					int_pend = 1'b1;
					int_sel = rems_pkg::VEC_IRQ0 + 6'(i); // [RULE13]
				end
			end
		end
		if (nmi_req) begin
			int_pend = 1'b1;
			int_sel = rems_pkg::VEC_NMI; // [RULE13]
		end
		// Nothing may interrupt until the first instruction has set the stack up.
		if (r.blocked) begin
			int_pend = 1'b0; // [RULE21] [RULE25]
		end
	end

	// ==========================================
	// Exception sequencer
	always_comb begin
		next_r = r;
		next_r.set_i = 1'b0;
		next_r.load_pc = 1'b0;
		next_r.load_sp = 1'b0;
		next_r.accept = 1'b0;
		next_r.latch = 1'b0;
		next_r.after_exc = 1'b0;
		if (!rn_sync) begin
			next_r.state = rems_pkg::ST_RESET; // [RULE8] [RULE15]
			next_r.halt = 1'b1;
			next_r.req = 1'b0;
			next_r.we = 1'b0;
			next_r.blocked = 1'b1;
			next_r.trap_pend = 1'b0;
		end else if (wdt_overflow) begin
			next_r.state = rems_pkg::ST_WDT; // [RULE17]
			next_r.cnt = 4'(rems_pkg::WDT_HOLD_CYC);
			next_r.halt = 1'b1;
			next_r.req = 1'b0;
			next_r.we = 1'b0;
			next_r.blocked = 1'b1;
			next_r.trap_pend = 1'b0;
		end else begin
			unique case (r.state)
				rems_pkg::ST_RESET, rems_pkg::ST_WDT: begin
					if (r.state == rems_pkg::ST_WDT && r.cnt != 4'h0) begin
						next_r.cnt = r.cnt - 4'h1;
					end else begin
						// Reset goes straight to the vector with no stack frame.
						next_r.state = rems_pkg::ST_VEC; // [RULE12] [RULE16]
						next_r.halt = 1'b0;
						next_r.latch = 1'b1;
						next_r.set_i = 1'b1; // [RULE20]
						next_r.accept = 1'b1;
						next_r.vec = rems_pkg::VEC_RESET;
						next_r.req = 1'b1;
						next_r.we = 1'b0;
						next_r.addr = {24'h000000, rems_pkg::VEC_RESET, 2'b00}; // [RULE20] [RULE24]
					end
				end
				rems_pkg::ST_PUSH: begin
					if (mem_ack) begin
						next_r.load_sp = 1'b1;
						next_r.sp = r.addr;
						next_r.set_i = 1'b1; // [RULE11]
						next_r.state = rems_pkg::ST_VEC;
						next_r.we = 1'b0;
						next_r.addr = {24'h000000, r.vec, 2'b00}; // [RULE24]
					end
				end
				rems_pkg::ST_VEC: begin
					if (mem_ack) begin
						next_r.req = 1'b0;
						next_r.load_pc = 1'b1;
						next_r.pc = mem_rdata; // [RULE11] [RULE20]
						if (r.vec == rems_pkg::VEC_RESET) begin
							next_r.state = rems_pkg::ST_FIRST; // [RULE22]
						end else begin
							next_r.state = rems_pkg::ST_RUN;
							next_r.after_exc = 1'b1; // [RULE10]
						end
					end
				end
				rems_pkg::ST_FIRST: begin
					if (instr_done) begin
						next_r.blocked = 1'b0; // [RULE25]
						next_r.state = rems_pkg::ST_RUN;
					end
				end
				rems_pkg::ST_RUN: begin
					if (int_pend && (instr_done || r.after_exc)) begin
						// A trap arriving together with an interrupt is kept for afterwards.
						next_r.vec = int_sel; // [RULE8] [RULE10]
						if (trap_instruction) begin
							next_r.trap_pend = 1'b1;
							next_r.trap_sel = trap_num;
						end
					end else if (trap_instruction || r.trap_pend) begin
						next_r.trap_pend = 1'b0; // [RULE9]
						next_r.vec = rems_pkg::VEC_TRAP0 + {4'h0, trap_instruction ? trap_num : r.trap_sel};
					end
					if ((int_pend && (instr_done || r.after_exc)) || trap_instruction || r.trap_pend) begin
						next_r.state = rems_pkg::ST_PUSH; // [RULE11]
						next_r.accept = 1'b1;
						next_r.req = 1'b1;
						next_r.we = 1'b1;
						next_r.addr = stack_pointer - rems_pkg::STACK_STEP;
						next_r.wdata = {condition_code_register, program_counter};
					end
				end
				default: begin
					next_r.state = rems_pkg::ST_RESET;
					next_r.halt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{state: rems_pkg::ST_RESET, cnt: 4'h0, vec: rems_pkg::VEC_RESET, trap_pend: 1'b0,
				trap_sel: 2'h0, after_exc: 1'b0, blocked: 1'b1, req: 1'b0, we: 1'b0,
				addr: 32'h00000000, wdata: 32'h00000000, halt: 1'b1, set_i: 1'b0,
				load_pc: 1'b0, pc: 32'h00000000, load_sp: 1'b0, sp: 32'h00000000,
				accept: 1'b0, latch: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================
	// Outputs
	assign mem_req = r.req;
	assign mem_we = r.we;
	assign mem_addr = r.addr;
	assign mem_wdata = r.wdata;
	assign cpu_halt = r.halt;
	assign periph_reset = r.halt; // [RULE15]
	assign cpu_hold = r.state != rems_pkg::ST_RUN && r.state != rems_pkg::ST_FIRST;
	assign set_i_mask = r.set_i;
	assign load_pc = r.load_pc;
	assign new_pc = r.pc;
	assign load_sp = r.load_sp;
	assign new_sp = r.sp;
	assign exc_accept = r.accept;
	assign exc_vector = r.vec;
	assign int_blocked = r.blocked;

endmodule

/* tb/rems_mem_model.sv */
`timescale 1ns/1ps
// ====================
// Memory on the far side of the bus
module rems_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [1:0] wait_cnt;
	// Between answers the data shows the inverse, so stale data never looks valid.
	assign mem_rdata = mem_ack ? {8'h5A, mem_addr[23:0]} : ~{8'h5A, mem_addr[23:0]};
	always_ff @(posedge clk) begin
		mem_ack <= 1'h0;
		if (rst || !mem_req || mem_ack) begin
			wait_cnt <= 2'h0;
		end else if (wait_cnt == {slow, slow}) begin
			mem_ack <= 1'h1;
			wait_cnt <= 2'h0;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule

/* tb/rems_sva.sv */
`timescale 1ns/1ps
// ====================
// Port checks
module rems_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_input_n,
	input wire logic wdt_overflow,
	input wire logic [7:0] area_bus_width_register,
	input wire logic [23:0] program_counter,
	input wire logic [7:0] condition_code_register,
	input wire logic [31:0] stack_pointer,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic cpu_halt,
	input wire logic set_i_mask,
	input wire logic load_pc,
	input wire logic [31:0] new_pc,
	input wire logic load_sp,
	input wire logic exc_accept,
	input wire logic [5:0] exc_vector,
	input wire logic int_blocked,
	input wire logic mode_valid,
	input wire logic [2:0] mode,
	input wire logic [23:0] addr_oe,
	input wire logic p5_addr_sel,
	input wire logic p4_data_sel,
	input wire logic bus16
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_push_done;
		mem_req && mem_we && mem_ack;
	endsequence
	sequence s_fetch;
		load_sp && set_i_mask && !mem_we && mem_addr == {24'h0, exc_vector, 2'h0};
	endsequence
	property p_vec_fetch;
		s_push_done |=> s_fetch;
	endproperty
	a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch wrong");
	property p_push;
		exc_accept && exc_vector != 6'h0 |-> mem_req && mem_we && mem_addr == stack_pointer - 32'h4
			&& mem_wdata == {condition_code_register, program_counter};
	endproperty
	a_push: assert property (p_push) else $error("stack push wrong");
	property p_reset_exc;
		exc_accept && exc_vector == 6'h0 |-> set_i_mask && mem_req && !mem_we && mem_addr == 32'h0;
	endproperty
	a_reset_exc: assert property (p_reset_exc) else $error("reset fetch wrong");
	property p_load_pc;
		mem_req && !mem_we && mem_ack |=> load_pc && !mem_req && new_pc == $past(mem_rdata);
	endproperty
	a_load_pc: assert property (p_load_pc) else $error("start address wrong");
	property p_rsv;
		exc_accept |-> !(exc_vector inside {[6'h1:6'h6]});
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved vector used");
	property p_block;
		int_blocked && exc_accept |-> exc_vector == 6'h0 || exc_vector inside {[6'h8:6'hB]};
	endproperty
	a_block: assert property (p_block) else $error("interrupt while blocked");
	property p_addr;
		mode_valid |-> addr_oe == (mode > 3'h2 ? 24'hFFFFFF : 24'h0FFFFF);
	endproperty
	a_addr: assert property (p_addr) else $error("address lines wrong");
	property p_port5;
		mode_valid |-> p5_addr_sel == (mode > 3'h2);
	endproperty
	a_port5: assert property (p_port5) else $error("port 5 role wrong");
	property p_bus;
		!$past(rst) |-> bus16 == |$past(area_bus_width_register) && p4_data_sel == bus16;
	endproperty
	a_bus: assert property (p_bus) else $error("bus mode wrong");
	property p_halt;
		!reset_input_n [*8] |-> cpu_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt in reset");
	property p_wdt;
		wdt_overflow && !cpu_halt |=> ##[0:2] cpu_halt ##[1:20] (exc_accept && exc_vector == 6'h0);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
endmodule
bind rems_top rems_sva i_sva(.*);

/* tb/tb_top.sv */
`timescale 1ns/1ps
// ====================
// Bench
module tb_top;
	logic clk = 1'h0;
	logic rst, reset_input_n, wdt_overflow, nmi_req, int_req, trap_instruction, instr_done, slow, mem_ack;
	logic mem_req, mem_we, cpu_halt, periph_reset, cpu_hold, set_i_mask, load_pc, load_sp, exc_accept;
	logic int_blocked, mode_valid, p5_addr_sel, p4_data_sel, bus16;
	logic [1:0] trap_num;
	logic [2:0] mode_select_pins, mode;
	logic [5:0] int_vec, exc_vector;
	logic [7:0] area_bus_width_register, external_request_inputs, condition_code_register, abw_init, area16;
	logic [23:0] program_counter, addr_oe;
	logic [31:0] stack_pointer, mem_rdata, mem_addr, mem_wdata, new_pc, new_sp;
	int errors = 0;
	int checks_done = 0;
	rems_top i_dut(.*);
	rems_mem_model i_mem(.*);
	always #2.5 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_for(ref logic sig);
		int n = 0;
		while (sig !== 1'h1) begin
			cyc(1);
			n++;
			if (n > 300) begin
				errors++;
				end_sim();
			end
		end
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			cyc(1);
			chk(exc_accept, 32'h0);
		end
	endtask
	task automatic step(input logic d, input logic t);
		instr_done = d;
		trap_instruction = t;
		cyc(1);
		{instr_done, trap_instruction} = 2'h0;
	endtask
	task automatic do_reset(input logic [2:0] m);
		mode_select_pins = m;
		area_bus_width_register = m[0] ? 8'h00 : 8'hFF;
		reset_input_n = 1'h0;
		cyc(12);
		chk({cpu_halt, periph_reset, cpu_hold}, 32'h7);
		reset_input_n = 1'h1;
		wait_for(exc_accept);
		chk(exc_vector, 32'h0);
		chk({set_i_mask, mem_we, mem_addr[29:0]}, 32'h80000000);
		wait_for(load_pc);
		chk(new_pc, 32'h5A000000);
		chk(int_blocked, 32'h1);
		chk(cpu_hold, 32'h0);
		chk({mode_valid, mode}, {m != 3'h0, m});
		chk(addr_oe, m > 3'h2 ? 24'hFFFFFF : 24'h0FFFFF);
		chk(p5_addr_sel, m > 3'h2);
		chk(abw_init, m == 3'h2 || m == 3'h4 ? 8'hFF : 8'h00);
		chk(p4_data_sel, !m[0]);
	endtask
	task automatic take(input logic [5:0] v);
		wait_for(exc_accept);
		{nmi_req, int_req, external_request_inputs} = 10'h0;
		chk(exc_vector, v);
		chk(mem_we, 32'h1);
		chk(mem_wdata, {condition_code_register, program_counter});
		wait_for(load_sp);
		chk(set_i_mask, 32'h1);
		chk(new_sp, stack_pointer - 32'h4);
		chk(mem_addr, {24'h0, v, 2'h0});
		wait_for(load_pc);
		chk(new_pc, {8'h5A, 16'h0, v, 2'h0});
	endtask
	initial begin
		rst = 1'h1;
		// The power-up hold is far shorter than a board gives; the logic counts nothing on it.
		reset_input_n = 1'h0;
		{wdt_overflow, nmi_req, int_req, trap_instruction, instr_done, slow} = 6'h0;
		{trap_num, int_vec, external_request_inputs, condition_code_register} = 24'h0;
		area_bus_width_register = 8'h00;
		mode_select_pins = 3'h1;
		program_counter = 24'hABC123;
		stack_pointer = 32'h00FF0100;
		cyc(2);
		rst = 1'h0;
		for (int m = 0; m < 5; m++) begin
			slow = m[0];
			do_reset(m[2:0]);
		end
		nmi_req = 1'h1;
		quiet(6);
		step(1'h1, 1'h0);
		chk(int_blocked, 32'h0);
		quiet(4);
		step(1'h1, 1'h0);
		take(6'h07);
		for (int i = 0; i < 8; i++) begin
			area_bus_width_register = 8'h01 << i;
			cyc(2);
			chk(bus16, 32'h1);
			chk(area16, 8'h01 << i);
			area_bus_width_register = 8'h00;
			cyc(2);
			chk(p4_data_sel, 32'h0);
			external_request_inputs = 8'h01 << i;
			step(1'h1, 1'h0);
			take(6'(12 + i));
		end
		for (int v = 20; v < 61; v += 40) begin
			int_req = 1'h1;
			int_vec = 6'(v);
			step(1'h1, 1'h0);
			take(6'(v));
		end
		int_req = 1'h1;
		int_vec = 6'h13;
		step(1'h1, 1'h0);
		quiet(4);
		condition_code_register = 8'h80;
		external_request_inputs = 8'h01;
		step(1'h1, 1'h0);
		quiet(4);
		for (int t = 0; t < 4; t++) begin
			trap_num = 2'(t);
			step(1'h0, 1'h1);
			take(6'(8 + t));
		end
		condition_code_register = 8'h00;
		external_request_inputs = 8'h01;
		step(1'h1, 1'h1);
		take(6'h0C);
		take(6'h0B);
		wdt_overflow = 1'h1;
		cyc(1);
		wdt_overflow = 1'h0;
		wait_for(cpu_halt);
		wait_for(exc_accept);
		chk(exc_vector, 32'h0);
		wait_for(load_pc);
		chk(int_blocked, 32'h1);
		end_sim();
	end
endmodule
